// ---- fsup_fail_mode_supervisor.sv ----
// Operation
// - normal mode: channels driven by pwm module
// - filtered fail-force high forces fail mode
// - fail mode: channels follow filtered direct inputs
// - fail-force level readable as status bit
// - any link fault moves normal to fail
// - untoggled watchdog bit flags link fault
// - missing frame within timeout flags fault
// - bit count not multiple of 16 faults
// - link fault reported through link fault flag
// - flag held in fail, cleared leaving fail
// - fail-force and direct inputs deglitched symmetrically
// - long direct high drives matching channel in fail mode
// - reset pin deglitched on falling edge only
// - pwm clock deglitched; fast clock means fail
// - clock supervision from reset rise, low limit
// - pwm clock lost in normal mode: channels follow on/off requests
// - clock fail cleared after recovery and read
// - external switch follows setting in normal only
// - external switch low in sleep or fail
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// deglitch filter
// ----------------------------------------
module fsup_deglitch #(
	parameter int CYCLES = 4,
	parameter bit FALL_ONLY = 1'b0,
	parameter bit RST_VAL = 1'b0
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic raw,
	output logic filt
);
	import fsup_pkg::*;

	// cycles the raw level has differed from the filtered one
	logic [DGL_CW-1:0] cnt_q;
	logic filt_q;

	// filtered level flips only after a full quiet interval, except a FALL_ONLY rise, which passes at once
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			filt_q <= RST_VAL;
			cnt_q <= '0;
		end else if (raw == filt_q) begin
			// agreement restarts the interval, so glitches are dropped
			cnt_q <= '0;
		end else if (FALL_ONLY && raw) begin
			// rising edge passes at once
			filt_q <= 1'b1;
			cnt_q <= '0;
		end else if (cnt_q == DGL_CW'(CYCLES - 1)) begin
			filt_q <= raw;
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign filt = filt_q;
endmodule

// ----------------------------------------
// supervisor top
// ----------------------------------------
module fsup_fail_mode_supervisor #(
	parameter int WD_SHORT_CYCLES = fsup_pkg::WD_SHORT_CYC,
	parameter int WD_LONG_CYCLES = fsup_pkg::WD_LONG_CYC,
	parameter int CLK_LOW_CYCLES = fsup_pkg::CLK_LOW_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic fail_force_pin,
	input wire logic [fsup_pkg::NUM_CH-1:0] direct_channel_inputs,
	input wire logic pwm_clock_pin,
	input wire logic reset_input_n,
	input wire fsup_pkg::fsup_ctrl_t ctrl,
	output logic [fsup_pkg::NUM_CH-1:0] channel_drive,
	output logic external_switch_drive,
	output fsup_pkg::fsup_status_t status
);
	import fsup_pkg::*;

	// ----------------------------------------
	// link side (spi_sclk domain)
	// ----------------------------------------
	// bit counter kept modulo 16; gray copy is what crosses
	logic [FRAME_CW-1:0] lk_bin_q;
	logic [FRAME_CW-1:0] lk_gray_q;
	// last bit clocked in a frame carries the watchdog toggle bit
	logic lk_last_bit_q;

	// count bits only while chip select is active; the counter is never
	// cleared by the frame, so no edge after the last one is needed
	always_ff @(posedge spi_sclk or negedge resetn) begin
		if (!resetn) begin
			lk_bin_q <= '0;
			lk_gray_q <= '0;
			lk_last_bit_q <= 1'b0;
		end else if (!spi_cs_n) begin
			lk_bin_q <= lk_bin_q + 1'b1;
			lk_gray_q <= (lk_bin_q + 1'b1) ^ ((lk_bin_q + 1'b1) >> 1);
			lk_last_bit_q <= spi_mosi;
		end
	end

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] pin_s1_q;
	logic [SYNC_W-1:0] pin_s2_q;
	logic [FRAME_CW-1:0] gray_s1_q;
	logic [FRAME_CW-1:0] gray_s2_q;
	logic bit_s1_q;
	logic bit_s2_q;
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_d3_q;

	// two flops on every pin and link signal; stage two is read, plus a third chip select flop for the edge
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			gray_s1_q <= '0;
			gray_s2_q <= '0;
			bit_s1_q <= 1'b0;
			bit_s2_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_d3_q <= 1'b1;
		end else begin
			pin_s1_q <= {reset_input_n, pwm_clock_pin, direct_channel_inputs, fail_force_pin};
			pin_s2_q <= pin_s1_q;
			gray_s1_q <= lk_gray_q;
			gray_s2_q <= gray_s1_q;
			bit_s1_q <= lk_last_bit_q;
			bit_s2_q <= bit_s1_q;
			cs_s1_q <= spi_cs_n;
			cs_s2_q <= cs_s1_q;
			cs_d3_q <= cs_s2_q;
		end
	end

	// ----------------------------------------
	// input deglitchers
	// ----------------------------------------
	logic filt_fail;
	logic [NUM_CH-1:0] filt_direct;
	logic filt_clk;
	logic filt_rst_n;

	fsup_deglitch #(.CYCLES(DGL_IO_CYC), .FALL_ONLY(1'b0), .RST_VAL(1'b0)) u_dgl_fail (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.raw(pin_s2_q[SYNC_FAIL]),
		.filt(filt_fail)
	);

	// direct input filters, one per channel
	for (genvar g = 0; g < NUM_CH; g++) begin : g_dir
		fsup_deglitch #(.CYCLES(DGL_IO_CYC), .FALL_ONLY(1'b0), .RST_VAL(1'b0)) u_dgl_dir (
			.sys_clk(sys_clk),
			.resetn(resetn),
			.raw(pin_s2_q[SYNC_DIR_LO + g]),
			.filt(filt_direct[g])
		);
	end

	// pwm clock filter swallows pulses shorter than its interval
	fsup_deglitch #(.CYCLES(DGL_CLK_CYC), .FALL_ONLY(1'b0), .RST_VAL(1'b0)) u_dgl_clk (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.raw(pin_s2_q[SYNC_CLK]),
		.filt(filt_clk)
	);

	// reset pin: falling edge filtered, rising edge immediate
	fsup_deglitch #(.CYCLES(DGL_RST_CYC), .FALL_ONLY(1'b1), .RST_VAL(1'b0)) u_dgl_rst (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.raw(pin_s2_q[SYNC_RST]),
		.filt(filt_rst_n)
	);

	// ----------------------------------------
	// frame check
	// ----------------------------------------
	logic [FRAME_CW-1:0] frame_cnt;
	logic [FRAME_CW-1:0] prev_cnt_q;
	logic toggle_ref_q;
	logic frame_done;
	logic frame_ok;

	// gray back to binary
	always_comb begin
		frame_cnt[FRAME_CW-1] = gray_s2_q[FRAME_CW-1];
		for (int i = FRAME_CW - 2; i >= 0; i--) begin
			frame_cnt[i] = frame_cnt[i+1] ^ gray_s2_q[i];
		end
	end

	// chip select released marks the frame end
	assign frame_done = cs_s2_q && !cs_d3_q;
	// count since last frame end must be a multiple of 16
	// toggle bit must differ from the previous frame
	assign frame_ok = (frame_cnt == prev_cnt_q) && (bit_s2_q != toggle_ref_q);

	// references move on every frame end, good or bad
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			prev_cnt_q <= '0;
			toggle_ref_q <= TOGGLE_REF_RST;
		end else if (frame_done) begin
			prev_cnt_q <= frame_cnt;
			toggle_ref_q <= bit_s2_q;
		end
	end

	// ----------------------------------------
	// watchdog timeout
	// ----------------------------------------
	logic [WD_CW-1:0] wd_cnt_q;
	logic wd_expired_q;
	logic [WD_CW-1:0] wd_last;
	logic wd_timeout;

	assign wd_last = ctrl.watchdog_period_select ? WD_CW'(WD_LONG_CYCLES - 1)
		: WD_CW'(WD_SHORT_CYCLES - 1);
	// one event per expiry; counter parks until restarted
	assign wd_timeout = (wd_cnt_q >= wd_last) && !wd_expired_q;

	always_ff @(posedge sys_clk) begin
		if (!resetn || !filt_rst_n) begin
			wd_cnt_q <= '0;
			wd_expired_q <= 1'b0;
		end else if (frame_done && frame_ok) begin
			wd_cnt_q <= '0;
			wd_expired_q <= 1'b0;
		end else if (wd_timeout) begin
			wd_expired_q <= 1'b1;
		end else if (!wd_expired_q) begin
			wd_cnt_q <= wd_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------
	// pwm clock supervision
	// ----------------------------------------
	logic [CLKMON_CW-1:0] clk_gap_q;
	logic clk_prev_q;
	logic clk_bad_q;
	logic clk_fail_q;
	logic clk_edge;

	assign clk_edge = filt_clk && !clk_prev_q;

	// gap timer runs from reset pin rise; too long a gap is failure
	always_ff @(posedge sys_clk) begin
		if (!resetn || !filt_rst_n) begin
			clk_gap_q <= '0;
			clk_prev_q <= 1'b0;
			clk_bad_q <= 1'b0;
		end else begin
			clk_prev_q <= filt_clk;
			if (clk_edge) begin
				clk_gap_q <= '0;
				clk_bad_q <= 1'b0;
			end else if (clk_gap_q == CLKMON_CW'(CLK_LOW_CYCLES - 1)) begin
				clk_bad_q <= 1'b1;
			end else begin
				clk_gap_q <= clk_gap_q + 1'b1;
			end
		end
	end

	// diagnosis latch; a new failure beats a clearing read
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			clk_fail_q <= 1'b0;
		end else if (clk_bad_q) begin
			clk_fail_q <= 1'b1;
		end else if (ctrl.status1_read) begin
			clk_fail_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// mode control
	// ----------------------------------------
	fsup_state_t state_q;
	fsup_state_t state_d;
	logic comm_fault;
	logic link_fault_q;

	// bad frame or timeout is a link fault
	assign comm_fault = (frame_done && !frame_ok) || wd_timeout;

	always_comb begin
		state_d = state_q;
		case (state_q)
			FSUP_ST_SLEEP: begin
				state_d = filt_fail ? FSUP_ST_FAIL : FSUP_ST_NORMAL;
			end
			FSUP_ST_NORMAL: begin
				// fail-force or link fault enters fail mode
				if (filt_fail || comm_fault) begin
					state_d = FSUP_ST_FAIL;
				end
			end
			FSUP_ST_FAIL: begin
				// leave for normal only with fail-force low and a clean frame; a low reset pin still forces sleep
				if (!filt_fail && frame_done && frame_ok && !wd_timeout) begin
					state_d = FSUP_ST_NORMAL;
				end
			end
			default: begin
				state_d = FSUP_ST_SLEEP;
			end
		endcase
		if (!filt_rst_n) begin
			state_d = FSUP_ST_SLEEP;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_q <= FSUP_ST_SLEEP;
		end else begin
			state_q <= state_d;
		end
	end

	// fault flag: set wins, held in fail, cleared leaving fail
	always_ff @(posedge sys_clk) begin
		if (!resetn || !filt_rst_n) begin
			link_fault_q <= 1'b0;
		end else if (comm_fault) begin
			link_fault_q <= 1'b1;
		end else if (state_q == FSUP_ST_FAIL && state_d == FSUP_ST_NORMAL) begin
			link_fault_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic [NUM_CH-1:0] drive_q;
	logic ext_q;
	fsup_status_t status_q;

	// channel source by mode, registered so pins never see decode glitches
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			drive_q <= '0;
			ext_q <= 1'b0;
		end else begin
			case (state_q)
				FSUP_ST_NORMAL: begin
					// clock lost: plain on/off; else pwm
					drive_q <= clk_bad_q ? ctrl.channel_on_request : ctrl.pwm_drive;
					ext_q <= ctrl.ext_switch_setting;
				end
				FSUP_ST_FAIL: begin
					drive_q <= filt_direct;
					ext_q <= 1'b0;
				end
				default: begin
					drive_q <= '0;
					ext_q <= 1'b0;
				end
			endcase
		end
	end

	// status bits for the device status registers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			status_q <= '0;
		end else begin
			status_q.fail_mode <= (state_q == FSUP_ST_FAIL);
			status_q.link_fault_flag <= link_fault_q;
			status_q.fail_force_level <= filt_fail;
			status_q.clock_fail <= clk_fail_q;
			status_q.sleep_mode <= (state_q == FSUP_ST_SLEEP);
		end
	end

	assign channel_drive = drive_q;
	assign external_switch_drive = ext_q;
	assign status = status_q;
endmodule
`default_nettype wire

// ---- fsup_fail_mode_supervisor_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsup_fail_mode_supervisor_tb;
	import fsup_pkg::*;
	// shortened watchdog and clock-loss counts keep the run brief
	localparam int WD_S = 2000;
	localparam int WD_L = 8000;
	logic sys_clk = 1'b0;
	logic resetn, fail_force_pin, reset_input_n;
	// pwm clock pin has one driver only: the source process below
	logic pwm_clock_pin = 1'b0;
	logic spi_sclk, spi_cs_n, spi_mosi, external_switch_drive;
	logic [NUM_CH-1:0] direct_channel_inputs, channel_drive;
	fsup_ctrl_t ctrl;
	fsup_status_t status;
	int errors = 0, tests_run = 0, cyc = 0, pc = 0, half = 50;

	always #25 sys_clk = !sys_clk;

	fsup_fail_mode_supervisor #(.WD_SHORT_CYCLES(WD_S), .WD_LONG_CYCLES(WD_L),
		.CLK_LOW_CYCLES(300)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.fail_force_pin(fail_force_pin), .direct_channel_inputs(direct_channel_inputs),
		.pwm_clock_pin(pwm_clock_pin), .reset_input_n(reset_input_n), .ctrl(ctrl),
		.channel_drive(channel_drive), .external_switch_drive(external_switch_drive),
		.status(status));
	fsup_host_model u_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi));

	// pwm clock source (huge half = stopped) and the hang limit
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		pc <= pc + 1;
		if (pc >= half) begin
			pc <= 0;
			pwm_clock_pin <= !pwm_clock_pin;
		end
		if (cyc == 60000) begin
			errors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// a frame, then room for the sync, mode and status stages
	task automatic frame(input int n, input bit keep);
		u_host.send(n, keep);
		w(8);
	endtask
	task automatic read_q1();
		ctrl.status1_read <= 1'b1;
		w(1);
		ctrl.status1_read <= 1'b0;
		w(4);
	endtask

	initial begin
		resetn = 1'b0;
		fail_force_pin = 1'b0;
		reset_input_n = 1'b1;
		direct_channel_inputs = 4'h0;
		ctrl = '0;
		ctrl.pwm_drive = 4'h5;
		ctrl.channel_on_request = 4'h3;
		ctrl.ext_switch_setting = 1'b1;
		w(12);
		resetn <= 1'b1;
		w(10);
		frame(16, 1'b0);
		chk(status, 5'h00);
		chk(channel_drive, 4'h5);
		chk(external_switch_drive, 1'b1);
		frame(16, 1'b1);
		chk(status, 5'h18);
		chk({external_switch_drive, channel_drive}, 5'h00);
		frame(16, 1'b0);
		chk(status, 5'h00);
		// 15 and 17 bits are length faults, 16 is clean
		for (int n = 15; n <= 17; n++) begin
			frame(n, 1'b0);
			chk(status.fail_mode, n != 16);
			chk(status.link_fault_flag, n != 16);
			frame(16, 1'b0);
		end
		for (int s = 0; s < 2; s++) begin
			ctrl.watchdog_period_select <= s[0];
			frame(16, 1'b0);
			w((s ? WD_L : WD_S) - 300);
			chk(status.fail_mode, 1'b0);
			w(400);
			chk(status[4:3], 2'h3);
			frame(16, 1'b0);
		end
		// a short fail-force pulse must be filtered away
		fail_force_pin <= 1'b1;
		direct_channel_inputs <= 4'hA;
		w(3000);
		fail_force_pin <= 1'b0;
		w(1200);
		chk(status[4:2], 3'h0);
		frame(16, 1'b0);
		fail_force_pin <= 1'b1;
		w(4100);
		chk(status[4:2], 3'h5);
		chk(channel_drive, 4'hA);
		// a direct high must not reach the channels until it has lasted the filter time
		fail_force_pin <= 1'b0;
		direct_channel_inputs <= 4'hF;
		w(2000);
		chk(channel_drive, 4'hA);
		frame(16, 1'b0);
		w(2100);
		frame(16, 1'b0);
		chk(status[4:2], 3'h0);
		// clock stopped, then clock too fast for the filter
		for (int k = 0; k < 2; k++) begin
			frame(16, 1'b0);
			half <= k ? 10 : 100000;
			w(600);
			chk({status.clock_fail, channel_drive}, 5'h13);
			read_q1();
			chk(status.clock_fail, 1'b1);
			half <= 50;
			w(400);
			chk({status.clock_fail, channel_drive}, 5'h15);
			read_q1();
			chk(status.clock_fail, 1'b0);
		end
		reset_input_n <= 1'b0;
		w(100);
		reset_input_n <= 1'b1;
		w(10);
		chk(status.sleep_mode, 1'b0);
		reset_input_n <= 1'b0;
		w(260);
		chk({status.sleep_mode, external_switch_drive, channel_drive}, 6'h20);
		reset_input_n <= 1'b1;
		w(8);
		chk(status.sleep_mode, 1'b0);
		results();
	end
endmodule
`default_nettype wire

// ---- fsup_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side of the link
// ----------------------------------------
module fsup_host_model (
	input wire logic sys_clk,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi
);
	import fsup_pkg::*;
	// last toggle bit sent; zero at start like the device reference
	logic ref_q;
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b1;
		ref_q = 1'b0;
	end
	// one frame; link clock runs only inside it, 80 ns period
	// keep repeats the previous toggle bit, for fault scenarios only
	task automatic send(input int nbits, input bit keep);
		@(posedge sys_clk);
		#7 spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_mosi = (i == nbits - 1) ? (keep ? ref_q : !ref_q) : i[0];
			#40 spi_sclk = 1'b1;
			#40 spi_sclk = 1'b0;
		end
		#100 spi_cs_n = 1'b1;
		ref_q = spi_mosi;
		// released line shows the inverse, never a stale bit
		spi_mosi = !spi_mosi;
		#300;
	endtask
endmodule
`default_nettype wire

// ---- fsup_pkg.sv ----
`default_nettype none
package fsup_pkg;
	// ----------------------------------------
	// clock rate
	// ----------------------------------------
	localparam int SYS_CLK_MHZ = 20;
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int NUM_CH = 4;

	// ----------------------------------------
	// filter and supervision times
	// ----------------------------------------
	// symmetric deglitch on fail-force and direct inputs
	localparam int DGL_IO_US = 200;
	localparam int DGL_IO_CYC = DGL_IO_US * SYS_CLK_MHZ;
	// falling-edge deglitch on the reset pin
	localparam int DGL_RST_US = 10;
	localparam int DGL_RST_CYC = DGL_RST_US * SYS_CLK_MHZ;
	// symmetric deglitch on the pwm clock pin
	localparam int DGL_CLK_NS = 2000;
	localparam int DGL_CLK_CYC = DGL_CLK_NS * SYS_CLK_MHZ / 1000;
	// watchdog timeouts, split product keeps it below 2^31
	localparam int WD_SHORT_MS = 32;
	localparam int WD_LONG_MS = 128;
	localparam int WD_SHORT_CYC = WD_SHORT_MS * (SYS_CLK_HZ / 1000);
	localparam int WD_LONG_CYC = WD_LONG_MS * (SYS_CLK_HZ / 1000);
	// pwm clock low-frequency limit, as longest gap between edges
	localparam int CLK_LOW_HZ = 100;
	localparam int CLK_LOW_CYC = SYS_CLK_HZ / CLK_LOW_HZ;

	// ----------------------------------------
	// widths and positions
	// ----------------------------------------
	localparam int DGL_CW = 12;
	localparam int WD_CW = 22;
	localparam int CLKMON_CW = 18;
	localparam int FRAME_CW = 4;
	localparam int SYNC_W = 7;
	localparam int SYNC_FAIL = 0;
	localparam int SYNC_DIR_LO = 1;
	localparam int SYNC_CLK = 5;
	localparam int SYNC_RST = 6;
	localparam logic TOGGLE_REF_RST = 1'b0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		FSUP_ST_SLEEP = 3'h1,
		FSUP_ST_NORMAL = 3'h2,
		FSUP_ST_FAIL = 3'h4
	} fsup_state_t;

	// settings and strobes from the spi register logic (sys_clk domain)
	typedef struct packed {
		logic watchdog_period_select;
		logic status1_read;
		logic ext_switch_setting;
		logic [NUM_CH-1:0] channel_on_request;
		logic [NUM_CH-1:0] pwm_drive;
	} fsup_ctrl_t;

	// status bits handed back to the spi register logic
	typedef struct packed {
		logic fail_mode;
		logic link_fault_flag;
		logic fail_force_level;
		logic clock_fail;
		logic sleep_mode;
	} fsup_status_t;
endpackage
`default_nettype wire

// ---- fsup_sup_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the supervisor
// ----------------------------------------
module fsup_sup_asserts (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic reset_input_n,
	input wire fsup_pkg::fsup_ctrl_t ctrl,
	input wire logic [fsup_pkg::NUM_CH-1:0] channel_drive,
	input wire logic external_switch_drive,
	input wire fsup_pkg::fsup_status_t status
);
	import fsup_pkg::*;
	// edges since reset release; masks the sleep-to-normal settling
	logic [2:0] age_q;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end
	wire logic ok = (age_q == 3'h7);
	wire logic nrm = ok && !status.fail_mode && !status.sleep_mode;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	ext_off_a: assert property ((status.fail_mode || status.sleep_mode) |-> !external_switch_drive)
		else $error("external switch on outside normal mode");
	ext_follow_a: assert property ((nrm && $stable(ctrl.ext_switch_setting)) [*2]
		|-> external_switch_drive == ctrl.ext_switch_setting) else $error("external switch wrong");
	pwm_path_a: assert property ((nrm && !status.clock_fail && $stable(ctrl.pwm_drive)) [*3]
		|-> $past(channel_drive) == $past(ctrl.pwm_drive)) else $error("channels not from pwm");
	clk_hold_a: assert property ((status.clock_fail && !ctrl.status1_read
		&& !$past(ctrl.status1_read) && reset_input_n) |=> status.clock_fail)
		else $error("clock fail dropped without read");
	clk_clear_a: assert property (($fell(status.clock_fail) && ok && reset_input_n) |->
		$past(ctrl.status1_read) || $past(ctrl.status1_read, 2) || $past(ctrl.status1_read, 3))
		else $error("clock fail cleared without read");
	link_clear_a: assert property (($fell(status.fail_mode) && !status.sleep_mode)
		|-> !status.link_fault_flag) else $error("link fault kept after fail exit");
	link_hold_a: assert property ((status.link_fault_flag && status.fail_mode && reset_input_n)
		|=> status.link_fault_flag || !status.fail_mode) else $error("link fault lost in fail");
	link_fail_a: assert property (status.link_fault_flag |-> status.fail_mode)
		else $error("link fault outside fail mode");
	force_fail_a: assert property ((ok && status.fail_force_level && !status.sleep_mode) [*3]
		|-> status.fail_mode) else $error("fail force ignored");

	cover property (status.link_fault_flag);
	cover property (status.clock_fail && ctrl.status1_read);
	cover property (status.fail_force_level && status.fail_mode);
endmodule

bind fsup_fail_mode_supervisor fsup_sup_asserts u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.reset_input_n(reset_input_n), .ctrl(ctrl), .channel_drive(channel_drive),
	.external_switch_drive(external_switch_drive), .status(status));
`default_nettype wire
